// ===== src/ilpc_top.sv
// Interrupt controller and low-power control with AXI4-Lite registers
`timescale 1ns/1ps
//
// Summary of operation
// [RULE1] Mode strap sampled only during reset
// [RULE2] Shared flag pins still raise interrupts
// [RULE3] Fixed priority, power-down above all sources
// [RULE4] Fixed vector per source, step four
// [RULE5] Requests ANDed with mask, highest wins
// [RULE6] Power-down and reset ignore the mask
// [RULE7] Mask write blocks interrupts one cycle
// [RULE8] Nesting control selects pre-emption or sequential
// [RULE9] Edge or level choice for three pins
// [RULE10] Write-only force and clear register
// [RULE11] Status stack, twelve levels, auto push/pop
// [RULE12] Global enable gates all, set at reset
// [RULE13] Serial port 1 pins become two interrupts
// [RULE14] Power-down by pin or force bit
// [RULE15] Fast wake after 200 input clocks
// [RULE16] Crystal wake waits about 4096 clocks
// [RULE17] Context control: resume or cleared restart
// [RULE18] Acknowledge in power-down; reset ends it
// [RULE19] Idle stalls until unmasked interrupt
// [RULE20] Divided idle slows clock by 16-128
// [RULE21] Divided idle exit within divisor cycles
module ilpc_top #(
  parameter int WAKE_SLOW_CYC = 2 * ilpc_pkg::WAKE_XTAL_INPUT_CLOCK
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic ext_irq_2_n,
  input wire logic level_irq_0_n,
  input wire logic level_irq_1_n,
  input wire logic edge_irq_n,
  input wire logic ext_irq_0_n,
  input wire logic ext_irq_1_n,
  input wire logic sp1_irq_mode,
  input wire logic [4:0] int_src,
  input wire logic power_down_request_pin_n,
  input wire logic flag_pin_2_in,
  input wire logic [15:0] status_in,
  output ilpc_pkg::ilpc_vec_s vec_out,
  output logic mem_mode,
  output logic power_down_ack,
  output logic context_clear,
  output logic clk_en,
  output logic [7:0] clk_div,
  output logic [15:0] status_out,
  output logic stack_ovf
);
  import ilpc_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  localparam int NPIN = 8;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_d_r;
  wire [NPIN-1:0] pin_raw = {flag_pin_2_in, ~power_down_request_pin_n,
    ~ext_irq_1_n, ~ext_irq_0_n, ~edge_irq_n, ~level_irq_1_n,
    ~level_irq_0_n, ~ext_irq_2_n};
  wire [NPIN-1:0] pin_rise = pin_s2_r & ~pin_d_r;
  // Free running so the strap is seen while reset is held
  always_ff @(posedge clk) begin
    pin_s1_r <= pin_raw;
    pin_s2_r <= pin_s1_r;
    pin_d_r <= pin_s2_r;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [NSRC-1:0] interrupt_mask_register_r;
  logic [4:0] ictl_r;
  logic [2:0] pwr_r;
  logic [NSRC-1:0] edge_pend_r;
  logic [NSRC-1:0] active_r;
  logic pwd_pend_r;
  logic gie_r;
  logic mask_hold_r;
  ilpc_state_e state_r;
  logic [13:0] wait_r;
  logic [7:0] div_r;
  logic [7:0] divcnt_r;
  logic [15:0] stack_r [STACK_DEPTH];
  logic [3:0] sp_r;
  ilpc_vec_s vec_r;
  logic ctx_r;
  logic ovf_r;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire wr_go = s_awvalid & s_wvalid & ~s_bvalid;
  assign s_awready = wr_go;
  assign s_wready = wr_go;
  assign s_arready = ~s_rvalid;
  wire rd_go = s_arvalid & ~s_rvalid;
  wire wr_lo = wr_go & s_wstrb[0];
  wire w_interrupt_mask_register = wr_go & (s_awaddr == ADDR_INTERRUPT_MASK_REGISTER);
  wire w_ictl = wr_lo & (s_awaddr == ADDR_ICTL);
  wire w_ifc = wr_go & (s_awaddr == ADDR_IFC);
  wire w_cmd = wr_go & (s_awaddr == ADDR_CMD);
  wire w_pwr = wr_lo & (s_awaddr == ADDR_PWR);
  wire w_map = (s_awaddr == ADDR_INTERRUPT_MASK_REGISTER) | (s_awaddr == ADDR_ICTL) |
    (s_awaddr == ADDR_IFC) | (s_awaddr == ADDR_CMD) |
    (s_awaddr == ADDR_PWR);
  wire [NSRC-1:0] ifc_force = w_ifc ? s_wdata[NSRC-1:0] : '0; // [RULE10]
  wire [NSRC-1:0] ifc_clr = w_ifc ? s_wdata[NSRC+15:16] : '0; // [RULE10]
  wire cmd_ena = w_cmd & s_wdata[CMD_ENA];
  wire cmd_dis = w_cmd & s_wdata[CMD_DIS];
  wire cmd_rti = w_cmd & s_wdata[CMD_RTI];
  wire cmd_idle = w_cmd & s_wdata[CMD_IDLE];
  wire [1:0] cmd_div = s_wdata[CMD_DIVLO+1:CMD_DIVLO];
  wire cmd_divon = w_cmd & s_wdata[CMD_DIVLO+2];
  wire pd_force = w_cmd & s_wdata[CMD_PDFORCE];

  // ------------------------------------------------------------
  // Request assembly
  // ------------------------------------------------------------
  wire [NPIN-1:0] lvl = pin_s2_r;
  wire x2_e = ictl_r[ICTL_EDGE_X2]; // [RULE9]
  wire x1_e = ictl_r[ICTL_EDGE_X1]; // [RULE9]
  wire x0_e = ictl_r[ICTL_EDGE_X0]; // [RULE9]
  wire [NSRC-1:0] edge_set = {1'b0,
    sp1_irq_mode & x0_e & pin_rise[4],
    sp1_irq_mode & x1_e & pin_rise[5],
    1'b0, pin_rise[3], 4'h0, x2_e & pin_rise[0]}; // [RULE13]
  wire [NSRC-1:0] lvl_req = {1'b0,
    sp1_irq_mode ? (~x0_e & lvl[4]) : int_src[4],
    sp1_irq_mode ? (~x1_e & lvl[5]) : int_src[3],
    int_src[2], 1'b0, int_src[1], int_src[0], lvl[1], lvl[2],
    ~x2_e & lvl[0]}; // [RULE2] [RULE13]
  ilpc_req_s req;
  assign req.src = lvl_req | edge_pend_r;
  assign req.pwd_req = pwd_pend_r;

  // ------------------------------------------------------------
  // Priority selection
  // ------------------------------------------------------------
  function automatic logic [NSRC:0] first_set(input logic [NSRC-1:0] v);
    logic [NSRC:0] r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 10'(i)};
      end
    end
    return r;
  endfunction : first_set

  function automatic logic [NSRC-1:0] higher(input logic [NSRC-1:0] v);
    logic [NSRC-1:0] m;
    m = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (v[i]) begin
        m = (NSRC'(1) << i) - NSRC'(1);
        break;
      end
    end
    return m;
  endfunction : higher

  wire [NSRC-1:0] masked = req.src & interrupt_mask_register_r & {NSRC{~mask_hold_r}}; // [RULE5] [RULE7]
  wire nest_on = ictl_r[ICTL_NEST];
  wire [NSRC-1:0] allow = (active_r == '0) ? {NSRC{1'b1}} :
    (nest_on ? higher(active_r) : '0); // [RULE8]
  wire [NSRC-1:0] elig = masked & allow; // [RULE3]
  wire [NSRC:0] pick = first_set(elig);
  wire [3:0] pick_idx = pick[3:0];
  wire pick_ok = pick[NSRC];
  wire pwd_take = req.pwd_req & gie_r & (state_r == ILPC_RUN); // [RULE6] [RULE12]
  wire slow_ok = (div_r == '0) | (divcnt_r == '0); // [RULE21]
  wire can_take = (state_r == ILPC_RUN) | ((state_r == ILPC_IDLE) & slow_ok);
  wire src_take = pick_ok & gie_r & can_take & ~pwd_take; // [RULE12] [RULE19]
  wire [NSRC-1:0] pick_oh = src_take ? (NSRC'(1) << pick_idx) : '0;
  wire push = src_take | pwd_take;
  wire [NSRC-1:0] lowest_act = active_r & ~(active_r - NSRC'(1));

  // ------------------------------------------------------------
  // Interrupt state
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      interrupt_mask_register_r <= '0;
      ictl_r <= '0;
      pwr_r <= '0;
      edge_pend_r <= '0;
      active_r <= '0;
      pwd_pend_r <= 1'b0;
      gie_r <= 1'b1; // [RULE12]
      mask_hold_r <= 1'b0;
      vec_r <= '{valid: 1'b1, addr: VEC_RESET}; // [RULE4]
    end else begin
      if (w_interrupt_mask_register) interrupt_mask_register_r <= s_wdata[NSRC-1:0];
      mask_hold_r <= w_interrupt_mask_register; // [RULE7]
      if (w_ictl) ictl_r <= s_wdata[4:0];
      if (w_pwr) pwr_r <= s_wdata[2:0];
      // Set wins over software clear
      edge_pend_r <= ((edge_pend_r & ~ifc_clr & ~pick_oh) | ifc_force |
        edge_set); // [RULE10]
      pwd_pend_r <= (pwd_pend_r & ~pwd_take) | pin_rise[6]; // [RULE6]
      if (cmd_ena) gie_r <= 1'b1;
      else if (cmd_dis) gie_r <= 1'b0; // [RULE12]
      active_r <= (active_r & ~(cmd_rti ? lowest_act : '0)) | pick_oh; // [RULE8]
      vec_r.valid <= push;
      if (pwd_take) vec_r.addr <= VEC_PWD; // [RULE4]
      else if (src_take) vec_r.addr <= VEC_BASE +
        16'(pick_idx) * VEC_STEP; // [RULE4]
    end
  end

  // ------------------------------------------------------------
  // Status stack, pushed on interrupt entry, popped on return command
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sp_r <= '0;
      ovf_r <= 1'b0;
    end else if (push & ~cmd_rti) begin
      if (sp_r == 4'(STACK_DEPTH)) ovf_r <= 1'b1;
      else sp_r <= sp_r + 4'h1; // [RULE11]
    end else if (cmd_rti & ~push & (sp_r != '0)) begin
      sp_r <= sp_r - 4'h1; // [RULE11]
    end
  end
  always_ff @(posedge clk) begin
    if (push & ~cmd_rti & (sp_r != 4'(STACK_DEPTH))) begin
      stack_r[sp_r] <= status_in; // [RULE11]
    end
  end
  assign status_out = (sp_r == '0) ? '0 : stack_r[sp_r - 4'h1];

  // ------------------------------------------------------------
  // Strap and low-power sequencing
  // ------------------------------------------------------------
  localparam int FAST_CYC = 2 * WAKE_FAST_INPUT_CLOCK;
  wire pd_req = pwd_take | pd_force; // [RULE14]
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= ILPC_RUN; // [RULE18]
      wait_r <= '0;
      div_r <= '0;
      divcnt_r <= '0;
      ctx_r <= 1'b0;
    end else begin
      divcnt_r <= (divcnt_r == '0) ? div_r : divcnt_r - 8'h1; // [RULE20]
      case (state_r)
        ILPC_RUN: begin
          if (pd_req) begin
            state_r <= ILPC_PDOWN; // [RULE14]
          end else if (cmd_idle) begin
            state_r <= ILPC_IDLE; // [RULE19]
            div_r <= cmd_divon ? (8'h10 << cmd_div) - 8'h1 : '0; // [RULE20]
          end
        end
        ILPC_IDLE: begin
          if (src_take) begin
            state_r <= ILPC_RUN; // [RULE19]
            div_r <= '0;
          end
        end
        ILPC_PDOWN: begin
          if (pwr_r[PWR_WAKE] | pin_rise[6]) begin
            state_r <= ILPC_WAKE;
            wait_r <= pwr_r[PWR_XTALOFF] ? 14'(WAKE_SLOW_CYC) :
              14'(FAST_CYC); // [RULE15] [RULE16]
          end
        end
        default: begin
          if (wait_r == '0) begin
            state_r <= ILPC_RUN;
            ctx_r <= pwr_r[PWR_CTXCLR]; // [RULE17]
          end else begin
            wait_r <= wait_r - 14'h1;
          end
        end
      endcase
    end
  end
  logic mm_r;
  always_ff @(posedge clk) begin
    if (!rstn) mm_r <= pin_s2_r[7]; // [RULE1]
  end

  assign mem_mode = mm_r;
  assign power_down_ack = (state_r == ILPC_PDOWN); // [RULE18]
  assign context_clear = ctx_r;
  assign clk_en = (state_r == ILPC_RUN) | (state_r == ILPC_IDLE & slow_ok);
  assign clk_div = div_r;
  assign vec_out = vec_r;
  assign stack_ovf = ovf_r;

  // ------------------------------------------------------------
  // Bus answers
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (s_araddr == ADDR_INTERRUPT_MASK_REGISTER) rd_mux = 32'(interrupt_mask_register_r);
    else if (s_araddr == ADDR_ICTL) rd_mux = 32'(ictl_r);
    else if (s_araddr == ADDR_STAT) rd_mux = {12'h0, sp_r, 2'h0, state_r,
      gie_r, mm_r, NSRC'(req.src)};
    else if (s_araddr == ADDR_VEC) rd_mux = 32'(vec_r.addr);
    else if (s_araddr == ADDR_PWR) rd_mux = 32'(pwr_r);
  end
  wire rd_map = (s_araddr == ADDR_INTERRUPT_MASK_REGISTER) | (s_araddr == ADDR_ICTL) |
    (s_araddr == ADDR_STAT) | (s_araddr == ADDR_VEC) |
    (s_araddr == ADDR_PWR) | (s_araddr == ADDR_IFC) |
    (s_araddr == ADDR_CMD);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp <= w_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) s_bvalid <= 1'b0;
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_mux; // [RULE10]
        s_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rready) s_rvalid <= 1'b0;
    end
  end
endmodule : ilpc_top

// ===== src/ilpc_pkg.sv
// Package for the interrupt and low-power controller
package ilpc_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_INTERRUPT_MASK_REGISTER = 8'h00;
  localparam logic [7:0] ADDR_ICTL = 8'h04;
  localparam logic [7:0] ADDR_IFC = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  localparam logic [7:0] ADDR_VEC = 8'h14;
  localparam logic [7:0] ADDR_PWR = 8'h18;
  // ------------------------------------------------------------
  // Sources, index 0 highest after power-down
  // ------------------------------------------------------------
  localparam int NSRC = 10;
  localparam int SRC_X2 = 0;
  localparam int SRC_L1 = 1;
  localparam int SRC_L0 = 2;
  localparam int SRC_S0T = 3;
  localparam int SRC_S0R = 4;
  localparam int SRC_E = 5;
  localparam int SRC_BD = 6;
  localparam int SRC_S1T = 7;
  localparam int SRC_S1R = 8;
  localparam int SRC_TMR = 9;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_PWD = 16'h002c;
  localparam logic [15:0] VEC_BASE = 16'h0004;
  localparam logic [15:0] VEC_STEP = 16'h0004;
  // ------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------
  localparam int ICTL_EDGE_X0 = 0;
  localparam int ICTL_EDGE_X1 = 1;
  localparam int ICTL_EDGE_X2 = 2;
  localparam int ICTL_NEST = 4;
  localparam int CMD_ENA = 0;
  localparam int CMD_DIS = 1;
  localparam int CMD_RTI = 2;
  localparam int CMD_IDLE = 3;
  localparam int CMD_DIVLO = 4;
  localparam int CMD_PDFORCE = 8;
  localparam int PWR_XTALOFF = 0;
  localparam int PWR_CTXCLR = 1;
  localparam int PWR_WAKE = 2;
  localparam int STACK_DEPTH = 12;
  // ------------------------------------------------------------
  // Timing (input clock cycles = half processor rate)
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int WAKE_FAST_INPUT_CLOCK = 200;
  localparam int WAKE_XTAL_INPUT_CLOCK = 4096;
  localparam logic [2:0] AXI_OKAY = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ILPC_RUN = 2'b00,
    ILPC_IDLE = 2'b01,
    ILPC_PDOWN = 2'b10,
    ILPC_WAKE = 2'b11
  } ilpc_state_e;

  typedef struct packed {
    logic [NSRC-1:0] src;
    logic pwd_req;
  } ilpc_req_s;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } ilpc_vec_s;
endpackage : ilpc_pkg

// ===== verification/ilpc_checker.sv
// Assertion checker for the interrupt and low-power controller
`timescale 1ns/1ps
module ilpc_checker
  import ilpc_pkg::*;
#(
  parameter int WAKE_SLOW_CYC = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_awvalid,
  input wire logic s_wvalid,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic [1:0] s_bresp,
  input wire logic s_arvalid,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [31:0] s_rdata,
  input wire ilpc_pkg::ilpc_vec_s vec_out,
  input wire logic mem_mode,
  input wire logic power_down_ack,
  input wire logic [7:0] clk_div,
  input wire logic stack_ovf
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  reset_vector_a: assert property ($rose(rstn) |-> vec_out.valid &&
    vec_out.addr == VEC_RESET) else $error("reset vector missing");
  vector_map_a: assert property (vec_out.valid |->
    vec_out.addr[1:0] == 2'h0 && vec_out.addr <= VEC_PWD)
    else $error("vector outside table");
  mode_hold_a: assert property ($past(rstn, 2) |-> $stable(mem_mode))
    else $error("memory mode changed after reset");
  reset_wake_a: assert property ($rose(rstn) |-> !power_down_ack)
    else $error("acknowledge survived reset");
  div_range_a: assert property (clk_div inside
    {8'h00, 8'h0f, 8'h1f, 8'h3f, 8'h7f}) else $error("bad divisor");
  ovf_sticky_a: assert property (stack_ovf |=> stack_ovf)
    else $error("overflow flag dropped");
  wr_answer_a: assert property (s_awvalid && s_wvalid && !s_bvalid
    |=> s_bvalid) else $error("write not answered");
  rd_answer_a: assert property (s_arvalid && !s_rvalid |=> s_rvalid)
    else $error("read not answered");
  bresp_hold_a: assert property (s_bvalid && !s_bready
    |=> s_bvalid && $stable(s_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_rvalid && !s_rready
    |=> s_rvalid && $stable(s_rdata)) else $error("read answer dropped");
  cover property (vec_out.valid && vec_out.addr == VEC_PWD);
  cover property ($rose(power_down_ack));
  cover property (clk_div == 8'h7f);
endmodule : ilpc_checker

bind ilpc_top ilpc_checker #(.WAKE_SLOW_CYC(WAKE_SLOW_CYC)) u_chk (
  .clk(clk), .rstn(rstn), .s_awvalid(s_awvalid), .s_wvalid(s_wvalid),
  .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
  .s_arvalid(s_arvalid), .s_rvalid(s_rvalid), .s_rready(s_rready),
  .s_rdata(s_rdata), .vec_out(vec_out), .mem_mode(mem_mode),
  .power_down_ack(power_down_ack), .clk_div(clk_div),
  .stack_ovf(stack_ovf)
);

// ===== verification/ilpc_pins_model.sv
// External devices on the interrupt, power-down and strap pins
`timescale 1ns/1ps
module ilpc_pins_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [6:0] assert_pin,
  input wire logic strap,
  output logic ext_irq_2_n,
  output logic level_irq_1_n,
  output logic level_irq_0_n,
  output logic edge_irq_n,
  output logic ext_irq_1_n,
  output logic ext_irq_0_n,
  output logic pd_pin_n,
  output logic flag_pin_2
);
  logic [6:0] pins_r;
  logic flag_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pins_r <= 7'h7f;
      flag_r <= 1'b0;
    end else begin
      pins_r <= ~assert_pin;
      flag_r <= ~flag_r;
    end
  end
  assign {pd_pin_n, ext_irq_0_n, ext_irq_1_n, edge_irq_n} = pins_r[6:3];
  assign {level_irq_0_n, level_irq_1_n, ext_irq_2_n} = pins_r[2:0];
  // Strap driven only in reset, then the pin toggles as a flag
  assign flag_pin_2 = rstn ? flag_r : strap;
endmodule : ilpc_pins_model

// ===== verification/ilpc_tb_top.sv
// Self-checking testbench for the interrupt and low-power controller
`timescale 1ns/1ps
module ilpc_tb_top;
  import ilpc_pkg::*;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, sp1;
  logic awready, wready, bvalid, arready, rvalid, clk_en, ovf;
  logic x2_n, l0_n, l1_n, e_n, x0_n, x1_n, pd_n, flag, mode, ack, ctx;
  logic [7:0] awaddr, araddr, clk_div;
  logic [31:0] wdata, rdata, rd_d;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic [15:0] stat, st_out, last_vec;
  logic [6:0] pin;
  logic [4:0] isrc;
  ilpc_vec_s vec;
  int n_vec = 0;
  int seen = 0;
  int n_mismatch = 0;
  int n_compared = 0;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ilpc_top #(.WAKE_SLOW_CYC(16)) uut (
    .clk(clk), .rstn(rstn), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .ext_irq_2_n(x2_n), .level_irq_0_n(l0_n), .level_irq_1_n(l1_n),
    .edge_irq_n(e_n), .ext_irq_0_n(x0_n), .ext_irq_1_n(x1_n),
    .sp1_irq_mode(sp1), .int_src(isrc), .power_down_request_pin_n(pd_n),
    .flag_pin_2_in(flag), .status_in(stat), .vec_out(vec),
    .mem_mode(mode), .power_down_ack(ack), .context_clear(ctx),
    .clk_en(clk_en), .clk_div(clk_div), .status_out(st_out),
    .stack_ovf(ovf)
  );

  ilpc_pins_model pm (
    .clk(clk), .rstn(rstn), .assert_pin(pin), .strap(1'b1),
    .ext_irq_2_n(x2_n), .level_irq_1_n(l1_n), .level_irq_0_n(l0_n),
    .edge_irq_n(e_n), .ext_irq_1_n(x1_n), .ext_irq_0_n(x0_n),
    .pd_pin_n(pd_n), .flag_pin_2(flag)
  );

  always @(posedge clk) begin
    if (rstn && vec.valid === 1'b1) begin
      last_vec <= vec.addr;
      n_vec <= n_vec + 1;
    end
  end
  // ----------------------------------------------------------
  // Bus, pin and compare tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    wr_r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    rd_d = rdata;
    rd_r = rresp;
  endtask : rd

  task automatic rst();
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    seen = n_vec;
  endtask : rst

  task automatic drv(input int i, input logic v);
    case (i)
      0, 1, 2: pin[i] <= v;
      3, 4: isrc[i-3] <= v;
      5: pin[3] <= v;
      6, 7, 8: isrc[i-4] <= v;
      9: if (v) wr(ADDR_IFC, 32'h0000_0200);
      10: pin[4] <= v;
      11: pin[5] <= v;
      default: pin[6] <= v;
    endcase
    if (!v) repeat (5) @(posedge clk);
  endtask : drv

  task automatic wv(input logic [15:0] e);
    int n;
    n = 0;
    while (n_vec == seen && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(32'(last_vec), 32'(e));
    seen = n_vec;
  endtask : wv

  task automatic nv();
    repeat (20) @(posedge clk);
    chk(32'(n_vec - seen), 32'h0);
  endtask : nv

  task automatic rti();
    wr(ADDR_CMD, 32'h4);
  endtask : rti

  task automatic wa();
    int n;
    n = 0;
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk(32'(ack), 32'h1);
  endtask : wa
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    rd(ADDR_STAT);
    chk(32'(rd_d[11:10]), 32'h3);
    chk(32'(mode), 32'h1);
    rd(8'h40);
    chk(32'(rd_r), 32'(RESP_SLVERR));
    rd(ADDR_IFC);
    chk(rd_d, 32'h0);
    wr(ADDR_INTERRUPT_MASK_REGISTER, 32'h3ff);
    chk(32'(wr_r), 32'(RESP_OKAY));
  endtask : t_reset

  task automatic t_each();
    int e;
    for (int i = 0; i < 12; i++) begin
      e = (i == 10) ? 7 : (i == 11) ? 8 : i;
      sp1 <= (i > 9);
      drv(i, 1'b1);
      wv(16'(4 + 4 * e));
      drv(i, 1'b0);
      rti();
    end
    wr(ADDR_ICTL, 32'h4);
    drv(0, 1'b1);
    wv(16'h0004);
    rti();
    nv();
    drv(0, 1'b0);
    wr(ADDR_ICTL, 32'h0);
  endtask : t_each

  task automatic t_mask();
    wr(ADDR_INTERRUPT_MASK_REGISTER, 32'h0);
    drv(2, 1'b1);
    nv();
    wr(ADDR_INTERRUPT_MASK_REGISTER, 32'h4);
    wv(16'h000c);
    drv(2, 1'b0);
    rti();
    wr(ADDR_CMD, 32'h2);
    drv(2, 1'b1);
    nv();
    wr(ADDR_CMD, 32'h1);
    wv(16'h000c);
    drv(2, 1'b0);
    rti();
    wr(ADDR_INTERRUPT_MASK_REGISTER, 32'h3ff);
  endtask : t_mask

  task automatic t_nest();
    drv(2, 1'b1);
    wv(16'h000c);
    drv(0, 1'b1);
    nv();
    drv(2, 1'b0);
    rti();
    wv(16'h0004);
    drv(0, 1'b0);
    rti();
    wr(ADDR_ICTL, 32'h10);
    stat <= 16'h1234;
    drv(2, 1'b1);
    wv(16'h000c);
    stat <= 16'h5678;
    drv(0, 1'b1);
    wv(16'h0004);
    chk(32'(st_out), 32'h5678);
    drv(0, 1'b0);
    rti();
    chk(32'(st_out), 32'h1234);
    chk(32'(ovf), 32'h0);
    drv(2, 1'b0);
    rti();
    wr(ADDR_ICTL, 32'h0);
  endtask : t_nest

  task automatic t_idle();
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_CMD, (k < 4) ? 32'(8 | (k << 4) | 64) : 32'h8);
      repeat (3) @(posedge clk);
      chk(32'(clk_div), (k < 4) ? 32'((16 << k) - 1) : 32'h0);
      drv(2, 1'b1);
      wv(16'h000c);
      drv(2, 1'b0);
      rti();
    end
  endtask : t_idle

  task automatic t_pd();
    wr(ADDR_INTERRUPT_MASK_REGISTER, 32'h0);
    drv(12, 1'b1);
    wv(VEC_PWD);
    wa();
    chk(32'(clk_en), 32'h0);
    drv(12, 1'b0);
    wr(ADDR_PWR, 32'h6);
    repeat (300) @(posedge clk);
    rd(ADDR_STAT);
    chk(32'(rd_d[13:12]), 32'h3);
    repeat (150) @(posedge clk);
    rd(ADDR_STAT);
    chk(32'(rd_d[13:12]), 32'h0);
    chk(32'(ctx), 32'h1);
    wr(ADDR_PWR, 32'h1);
    wr(ADDR_CMD, 32'h100);
    wa();
    wr(ADDR_PWR, 32'h5);
    repeat (30) @(posedge clk);
    rd(ADDR_STAT);
    chk(32'(rd_d[13:12]), 32'h0);
    wr(ADDR_PWR, 32'h1);
    wr(ADDR_CMD, 32'h100);
    wa();
    rst();
    chk(32'(ack), 32'h0);
  endtask : t_pd

  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, sp1} = 6'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    pin = 7'h00;
    isrc = 5'h00;
    stat = 16'h0000;
    rst();
    t_reset();
    t_each();
    t_mask();
    t_nest();
    t_idle();
    t_pd();
    print_verdict();
  end

  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : ilpc_tb_top
